/* include/pcirq_regs.vh */
// Offsets, field positions, reset values and timing counts of the interrupt and power block
`ifndef PCIRQ_REGS_VH
`define PCIRQ_REGS_VH

// Register offsets (byte addresses; power management register in configuration space, the rest in BAR space)
`define PCIRQ_OFF_PIN_POL       8'h04
`define PCIRQ_OFF_LOCAL_CTRL    8'h00
`define PCIRQ_OFF_UART_SRC      8'h18
`define PCIRQ_OFF_GLOBAL        8'h1C
`define PCIRQ_OFF_PM_CSR        8'h44

// Global register fields
`define PCIRQ_G_UART_LO         0
`define PCIRQ_G_SHARED0         4
`define PCIRQ_G_SHARED1         5
`define PCIRQ_G_PIN_LO          6
`define PCIRQ_G_UMASK_LO        16
`define PCIRQ_G_MASK0           20
`define PCIRQ_G_MASK1           21
`define PCIRQ_G_PMASK_LO        22
`define PCIRQ_G_RSVD31          31

// Reset values
`define PCIRQ_RST_UMASK         2'h3
`define PCIRQ_RST_PMASK         9'h1FF
`define PCIRQ_RST_IRQ_PIN       8'h01

// Local control fields
`define PCIRQ_LC_MODE_LO        5
`define PCIRQ_LC_MODE_HI        6

// Power management control/status fields
`define PCIRQ_PM_STATE_LO       0
`define PCIRQ_PM_EN             8
`define PCIRQ_PM_STATUS         15
`define PCIRQ_D0                2'h0
`define PCIRQ_D2                2'h2
`define PCIRQ_D3                2'h3

// Interrupt pin field codes
`define PCIRQ_PIN_NONE          8'h00
`define PCIRQ_PIN_A             8'h01
`define PCIRQ_PIN_B             8'h02

// Filter times in seconds and clock rate
`define PCIRQ_FILT1_S           4
`define PCIRQ_FILT2_S           129
`define PCIRQ_FILT3_S           518
`define PCIRQ_FILT3_EN_S        515
`define PCIRQ_CLK_HZ            100000000

`endif

/* rtl/pcirq_filter.v */
// Idle filter timer for the function-0 power-down request
`timescale 1ns/1ps
`include "pcirq_regs.vh"
module pcirq_filter #(
    parameter [47:0] T1_CYC = 48'd400000000,
    parameter [47:0] T2_CYC = 48'd12900000000,
    parameter [47:0] T3_CYC = 48'd51800000000,
    parameter [47:0] T3E_CYC = 48'd51500000000
) (
    input wire clk_sys_in,
    input wire resetn_in,
    input wire [1:0] mode_in,
    input wire irq_en_in,
    input wire idle_in,
    output reg expired_out
);
    reg [47:0] count_r;
    reg [47:0] limit;

    always @* begin
        case (mode_in)
            2'b01: limit = T1_CYC;
            2'b10: limit = T2_CYC;
            default: limit = irq_en_in ? T3E_CYC : T3_CYC;
        endcase
    end

    always @(posedge clk_sys_in) begin
        if (!resetn_in) begin
            count_r <= 48'h0000_0000_0000;
            expired_out <= 1'b0;
        end else if (!idle_in || mode_in == 2'b00) begin
            count_r <= 48'h0000_0000_0000;
            expired_out <= 1'b0;
        end else if (count_r >= limit - 48'd1) begin
            expired_out <= 1'b1;
        end else begin
            count_r <= count_r + 48'd1;
        end
    end
endmodule // pcirq_filter

/* rtl/pcirq_sync.v */
// Two-stage synchroniser for a bundle of asynchronous pin levels
`timescale 1ns/1ps
module pcirq_sync #(
    parameter WIDTH = 1
) (
    input wire clk_sys_in,
    input wire resetn_in,
    input wire [WIDTH-1:0] async_in,
    output reg [WIDTH-1:0] sync_out
);
    reg [WIDTH-1:0] meta_r;

    always @(posedge clk_sys_in) begin
        if (!resetn_in) begin
            meta_r <= {WIDTH{1'b0}};
            sync_out <= {WIDTH{1'b0}};
        end else begin
            meta_r <= async_in;
            sync_out <= meta_r;
        end
    end
endmodule // pcirq_sync

/* rtl/pcirq_top.v */
// Interrupt aggregation, routing and per-function power management for a dual-function target
`timescale 1ns/1ps
`include "pcirq_regs.vh"
module pcirq_top #(
    parameter [47:0] FILT1_CYC = `PCIRQ_FILT1_S * 48'd100000000,
    parameter [47:0] FILT2_CYC = `PCIRQ_FILT2_S * 48'd100000000,
    parameter [47:0] FILT3_CYC = `PCIRQ_FILT3_S * 48'd100000000,
    parameter [47:0] FILT3E_CYC = `PCIRQ_FILT3_EN_S * 48'd100000000
) (
    input wire clk_sys_in,
    input wire resetn_in,
    // Register access from the target's decoder
    input wire reg_wr_in,
    input wire reg_rd_in,
    input wire [7:0] reg_addr_in,
    input wire [31:0] reg_wdata_in,
    input wire reg_func_in,
    input wire reg_cfg_in,
    output reg [31:0] reg_rdata_out,
    output reg reg_ack_out,
    // EEPROM load of defaults
    input wire ee_load_in,
    input wire [1:0] ee_umask_in,
    input wire [7:0] ee_pin_f0_in,
    input wire [7:0] ee_pin_f1_in,
    // Sources
    input wire [10:0] multi_purpose_pin_in,
    input wire [1:0] uart_irq_in,
    input wire [1:0] uart_idle_in,
    input wire [1:0] uart_wake_in,
    input wire [23:0] uart_source_summary_in,
    input wire par_irq_in,
    input wire dev_mode_in,
    input wire minipci_in,
    input wire clkrun_n_in,
    // Outputs
    output reg inta_n_out,
    output reg intb_n_out,
    output reg intb_oe_out,
    output reg pme_n_out,
    output reg uart_clk_en_out,
    output reg bar_en_f0_out,
    output reg bar_en_f1_out
);
    ////////////////////////////////////////////////////////////////////////
    // Registers
    reg [31:0] global_irq_status_mask_reg;
    reg [31:0] pin_polarity_config_reg;
    reg [31:0] local_control_reg;
    reg [15:0] pm_csr_f0_r;
    reg [15:0] pm_csr_f1_r;
    reg [7:0] irq_pin_f0_r;
    reg [7:0] irq_pin_f1_r;
    reg pd_sticky_r;
    wire [10:0] pin_sync;
    wire [1:0] par_sync_w;
    wire pd_expired;
    wire [10:0] pin_int;
    wire [1:0] mode;
    wire pd_mode;
    wire [1:0] uart_status;
    wire bit4;
    wire bit5;
    wire [31:0] status_word;
    wire f0_low;
    wire f1_low;
    wire src_f0;
    wire src_f1;
    wire wake_f0;
    wire wake_f1;
    wire sel_g;
    wire sel_p0;
    wire sel_p1;
    wire pd_read;
    // Decoded selects, requests and routing
    wire sel_pol;
    wire sel_lc;
    wire sel_us;
    wire bar_ok;
    wire [8:0] pin_req;
    wire uart_req;
    wire pd_req;
    wire f0_on_a;
    wire f0_on_b;
    wire f1_on_a;
    wire f1_on_b;
    wire pull_a;
    wire pull_b;
    genvar g;

    pcirq_sync #(.WIDTH(11)) u_pin_sync (
        .clk_sys_in(clk_sys_in),
        .resetn_in(resetn_in),
        .async_in(multi_purpose_pin_in),
        .sync_out(pin_sync)
    );

    pcirq_sync #(.WIDTH(2)) u_misc_sync (
        .clk_sys_in(clk_sys_in),
        .resetn_in(resetn_in),
        .async_in({par_irq_in, clkrun_n_in}),
        .sync_out(par_sync_w)
    );

    assign mode = local_control_reg[`PCIRQ_LC_MODE_HI:`PCIRQ_LC_MODE_LO];
    assign pd_mode = (mode != 2'b00);

    // Idle means both channels quiet and no interrupt pending
    pcirq_filter #(
        .T1_CYC(FILT1_CYC),
        .T2_CYC(FILT2_CYC),
        .T3_CYC(FILT3_CYC),
        .T3E_CYC(FILT3E_CYC)
    ) u_filter (
        .clk_sys_in(clk_sys_in),
        .resetn_in(resetn_in),
        .mode_in(mode),
        .irq_en_in(global_irq_status_mask_reg[`PCIRQ_G_MASK1]),
        .idle_in(&uart_idle_in & ~|uart_irq_in),
        .expired_out(pd_expired)
    );

    ////////////////////////////////////////////////////////////////////////
    // Status composition
    // Per-pin polarity, then the per-pin mask for pins 2 to 10
    generate
        for (g = 0; g < 11; g = g + 1) begin : g_pin
            assign pin_int[g] = pin_sync[g] ^ pin_polarity_config_reg[g];
            if (g >= 2) begin : g_mask
                assign pin_req[g-2] = pin_int[g]
                    & global_irq_status_mask_reg[`PCIRQ_G_PMASK_LO+g-2];
            end
        end
    endgenerate
    assign uart_status = {~uart_source_summary_in[6], ~uart_source_summary_in[0]};
    assign bit4 = dev_mode_in ? par_sync_w[1] : pin_int[0];
    assign bit5 = pd_mode ? pd_sticky_r : pin_int[1];
    assign status_word = {global_irq_status_mask_reg[31:16], 1'b0, pin_int[10:2],
                          bit5, bit4, 2'b00, uart_status};

    // Register selects
    assign sel_g = (reg_addr_in == `PCIRQ_OFF_GLOBAL);
    assign sel_pol = (reg_addr_in == `PCIRQ_OFF_PIN_POL);
    assign sel_lc = (reg_addr_in == `PCIRQ_OFF_LOCAL_CTRL);
    assign sel_us = (reg_addr_in == `PCIRQ_OFF_UART_SRC);
    assign sel_p0 = reg_cfg_in && !reg_func_in && (reg_addr_in == `PCIRQ_OFF_PM_CSR);
    assign sel_p1 = reg_cfg_in && reg_func_in && (reg_addr_in == `PCIRQ_OFF_PM_CSR);
    // BAR space blocked while the addressed function is asleep
    assign f0_low = pm_csr_f0_r[1];
    assign f1_low = pm_csr_f1_r[1];
    assign bar_ok = !reg_cfg_in && !(reg_func_in ? f1_low : f0_low);
    // A BAR read of the global word in power-down mode clears bit 5 unless the filter is still expired
    assign pd_read = reg_rd_in && bar_ok && sel_g && pd_mode;

    ////////////////////////////////////////////////////////////////////////
    // Source gating
    assign uart_req = |(uart_irq_in & global_irq_status_mask_reg[17:16]);
    // Power-down request reaches the pin only with mask bit 21
    assign pd_req = pd_mode && pd_sticky_r
                    && global_irq_status_mask_reg[`PCIRQ_G_MASK1];
    assign src_f0 = !f0_low && (uart_req || pd_req);
    assign src_f1 = !f1_low && (
        |pin_req
        || (bit4 && global_irq_status_mask_reg[`PCIRQ_G_MASK0])
        || (!pd_mode && pin_int[1] && global_irq_status_mask_reg[`PCIRQ_G_MASK1]));
    // Wake sources only count while the function sleeps
    assign wake_f0 = |uart_wake_in && f0_low;
    assign wake_f1 = pin_int[2] && f1_low && local_control_reg[7];

    ////////////////////////////////////////////////////////////////////////
    // Interrupt pin routing per function; reserved codes drive nothing
    assign f0_on_a = (irq_pin_f0_r == `PCIRQ_PIN_A);
    assign f0_on_b = (irq_pin_f0_r == `PCIRQ_PIN_B);
    assign f1_on_a = (irq_pin_f1_r == `PCIRQ_PIN_A);
    assign f1_on_b = (irq_pin_f1_r == `PCIRQ_PIN_B);
    assign pull_a = (src_f0 && f0_on_a) || (src_f1 && f1_on_a);
    assign pull_b = (src_f0 && f0_on_b) || (src_f1 && f1_on_b);

    ////////////////////////////////////////////////////////////////////////
    // Register writes and sticky bits
    always @(posedge clk_sys_in) begin
        if (!resetn_in) begin
            global_irq_status_mask_reg <= {1'b1, `PCIRQ_RST_PMASK, 1'b1, 1'b1, 2'b00,
                                           `PCIRQ_RST_UMASK, 16'h0000};
            pin_polarity_config_reg <= 32'h0000_0000;
            local_control_reg <= 32'h0000_0000;
            pm_csr_f0_r <= 16'h0000;
            pm_csr_f1_r <= 16'h0000;
            irq_pin_f0_r <= `PCIRQ_RST_IRQ_PIN;
            irq_pin_f1_r <= `PCIRQ_RST_IRQ_PIN;
            pd_sticky_r <= 1'b0;
        end else begin
            if (ee_load_in) begin
                global_irq_status_mask_reg[17:16] <= ee_umask_in;
                irq_pin_f0_r <= ee_pin_f0_in;
                irq_pin_f1_r <= ee_pin_f1_in;
            end else if (reg_wr_in && bar_ok) begin
                if (sel_g)
                    global_irq_status_mask_reg[31:16] <= reg_wdata_in[31:16];
                else if (sel_pol)
                    pin_polarity_config_reg <= reg_wdata_in;
                else if (sel_lc)
                    local_control_reg <= reg_wdata_in;
            end
            // state field only moves on host writes
            if (reg_wr_in && sel_p0) begin
                pm_csr_f0_r[1:0] <= reg_wdata_in[1:0];
                pm_csr_f0_r[`PCIRQ_PM_EN] <= reg_wdata_in[`PCIRQ_PM_EN];
            end
            if (reg_wr_in && sel_p1) begin
                pm_csr_f1_r[1:0] <= reg_wdata_in[1:0];
                pm_csr_f1_r[`PCIRQ_PM_EN] <= reg_wdata_in[`PCIRQ_PM_EN];
            end
            if (wake_f0 && pm_csr_f0_r[`PCIRQ_PM_EN])
                pm_csr_f0_r[`PCIRQ_PM_STATUS] <= 1'b1;
            else if (reg_wr_in && sel_p0 && reg_wdata_in[`PCIRQ_PM_STATUS])
                pm_csr_f0_r[`PCIRQ_PM_STATUS] <= 1'b0;
            if (wake_f1 && pm_csr_f1_r[`PCIRQ_PM_EN])
                pm_csr_f1_r[`PCIRQ_PM_STATUS] <= 1'b1;
            else if (reg_wr_in && sel_p1 && reg_wdata_in[`PCIRQ_PM_STATUS])
                pm_csr_f1_r[`PCIRQ_PM_STATUS] <= 1'b0;
            if (pd_mode && pd_expired)
                pd_sticky_r <= 1'b1;
            else if (pd_read || !pd_mode)
                pd_sticky_r <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read data, pins and power actions
    always @(posedge clk_sys_in) begin
        if (!resetn_in) begin
            reg_rdata_out <= 32'h0000_0000;
            reg_ack_out <= 1'b0;
            inta_n_out <= 1'b1;
            intb_n_out <= 1'b1;
            intb_oe_out <= 1'b0;
            pme_n_out <= 1'b1;
            uart_clk_en_out <= 1'b1;
            bar_en_f0_out <= 1'b1;
            bar_en_f1_out <= 1'b1;
        end else begin
            reg_ack_out <= reg_rd_in || reg_wr_in;
            reg_rdata_out <= 32'h0000_0000;
            if (reg_rd_in) begin
                if (sel_p0)
                    reg_rdata_out <= {16'h0000, pm_csr_f0_r};
                else if (sel_p1)
                    reg_rdata_out <= {16'h0000, pm_csr_f1_r};
                else if (!bar_ok)
                    reg_rdata_out <= 32'h0000_0000;
                else if (sel_g)
                    reg_rdata_out <= status_word;
                else if (sel_pol)
                    reg_rdata_out <= pin_polarity_config_reg;
                else if (sel_lc)
                    reg_rdata_out <= local_control_reg;
                else if (sel_us)
                    reg_rdata_out <= {8'h00, uart_source_summary_in};
            end
            // open-drain style level, low while any unmasked source of an awake function routed to pin A holds
            inta_n_out <= !pull_a;
            if (minipci_in) begin
                intb_n_out <= par_sync_w[0];
                intb_oe_out <= 1'b0;
            end else begin
                intb_n_out <= !pull_b;
                intb_oe_out <= pull_b;
            end
            pme_n_out <= !((pm_csr_f0_r[`PCIRQ_PM_STATUS] && pm_csr_f0_r[`PCIRQ_PM_EN])
                           || (pm_csr_f1_r[`PCIRQ_PM_STATUS]
                               && pm_csr_f1_r[`PCIRQ_PM_EN]));
            uart_clk_en_out <= !f0_low;
            bar_en_f0_out <= !f0_low;
            bar_en_f1_out <= !f1_low;
        end
    end
endmodule // pcirq_top

/* tb/pcirq_host.sv */
// Host interrupt router and wake monitor
`timescale 1ns/1ps
module pcirq_host (
    input wire clk_sys_in,
    input wire inta_n_in,
    input wire intb_n_in,
    input wire intb_oe_in,
    input wire pme_n_in,
    output reg irq_a_out,
    output reg irq_b_out,
    output reg pme_out
);
    // Shared line with pull-up: released means high
    wire intb_line = intb_oe_in ? intb_n_in : 1'h1;
    always @(posedge clk_sys_in) begin
        irq_a_out <= !inta_n_in;
        irq_b_out <= !intb_line;
        pme_out <= !pme_n_in;
    end
endmodule // pcirq_host

/* tb/pcirq_props.sv */
// Port assertions for the interrupt and power block
`timescale 1ns/1ps
module pcirq_props (
    input wire clk_sys_in,
    input wire resetn_in,
    input wire reg_wr_in,
    input wire reg_rd_in,
    input wire reg_func_in,
    input wire reg_cfg_in,
    input wire [31:0] reg_rdata_out,
    input wire reg_ack_out,
    input wire minipci_in,
    input wire intb_n_out,
    input wire intb_oe_out,
    input wire pme_n_out,
    input wire uart_clk_en_out,
    input wire bar_en_f0_out,
    input wire bar_en_f1_out
);
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!resetn_in);
    a_ack_after_req:
        assert property ((reg_rd_in || reg_wr_in) |=> reg_ack_out) else $error("no ack");
    a_bar_read_blocked:
        assert property (reg_rd_in && !reg_cfg_in && !reg_func_in && !bar_en_f0_out
            && !$past(reg_wr_in) |=> reg_rdata_out == 32'h0000_0000) else $error("bar read");
    a_gate_pair_tied:
        assert property (uart_clk_en_out == bar_en_f0_out) else $error("gate split");
    a_minipci_no_oe:
        assert property (minipci_in && $past(minipci_in) |-> !intb_oe_out) else $error("oe");
    a_oe_drives_low:
        assert property (intb_oe_out |-> !intb_n_out) else $error("oe high");
    a_idle_released:
        assert property (!minipci_in && !$past(minipci_in) && !intb_oe_out |-> intb_n_out)
            else $error("intb low");
    a_pme_clear_write:
        assert property ($rose(pme_n_out) |-> $past(reg_wr_in) || $past(reg_wr_in, 2))
            else $error("pme dropped");
    a_state_by_host:
        assert property ($changed(uart_clk_en_out) || $changed(bar_en_f1_out)
            |-> $past(reg_wr_in) || $past(reg_wr_in, 2)) else $error("state moved");
endmodule // pcirq_props
bind pcirq_top pcirq_props i_pcirq_props (.clk_sys_in(clk_sys_in), .resetn_in(resetn_in),
    .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_func_in(reg_func_in),
    .reg_cfg_in(reg_cfg_in), .reg_rdata_out(reg_rdata_out), .reg_ack_out(reg_ack_out),
    .minipci_in(minipci_in), .intb_n_out(intb_n_out), .intb_oe_out(intb_oe_out),
    .pme_n_out(pme_n_out), .uart_clk_en_out(uart_clk_en_out),
    .bar_en_f0_out(bar_en_f0_out), .bar_en_f1_out(bar_en_f1_out));

/* tb/pcirq_top_tb.sv */
// Self-checking bench for the interrupt and power block
`timescale 1ns/1ps
module pcirq_top_tb;
    reg clk_sys_in = 1'h0, resetn_in = 1'h0, reg_wr_in = 1'h0, reg_rd_in = 1'h0;
    reg reg_func_in = 1'h0, reg_cfg_in = 1'h0, ee_load_in = 1'h0, par_irq_in = 1'h0;
    reg dev_mode_in = 1'h0, minipci_in = 1'h0, clkrun_n_in = 1'h1;
    reg [7:0] reg_addr_in = 8'h00, ee_pin_f0_in = 8'h01, ee_pin_f1_in = 8'h01;
    reg [31:0] reg_wdata_in = 32'h0000_0000, rd, rnd;
    reg [1:0] ee_umask_in = 2'h3, uart_irq_in = 2'h0, uart_idle_in = 2'h0;
    reg [1:0] uart_wake_in = 2'h0;
    reg [10:0] multi_purpose_pin_in = 11'h000, pol;
    reg [23:0] uart_source_summary_in = 24'h00_0041;
    wire [31:0] reg_rdata_out;
    wire reg_ack_out, inta_n_out, intb_n_out, intb_oe_out, pme_n_out, irq_a, irq_b, pme;
    wire uart_clk_en_out, bar_en_f0_out, bar_en_f1_out;
    integer num_errors = 0, checked = 0, cycles = 0, i;
    pcirq_top #(.FILT1_CYC(48'h14), .FILT2_CYC(48'h28), .FILT3_CYC(48'h3c),
        .FILT3E_CYC(48'h32)) i_pcirq_top (.clk_sys_in(clk_sys_in), .resetn_in(resetn_in),
        .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_addr_in(reg_addr_in),
        .reg_wdata_in(reg_wdata_in), .reg_func_in(reg_func_in), .reg_cfg_in(reg_cfg_in),
        .reg_rdata_out(reg_rdata_out), .reg_ack_out(reg_ack_out), .ee_load_in(ee_load_in),
        .ee_umask_in(ee_umask_in), .ee_pin_f0_in(ee_pin_f0_in), .ee_pin_f1_in(ee_pin_f1_in),
        .multi_purpose_pin_in(multi_purpose_pin_in), .uart_irq_in(uart_irq_in),
        .uart_idle_in(uart_idle_in), .uart_wake_in(uart_wake_in),
        .uart_source_summary_in(uart_source_summary_in), .par_irq_in(par_irq_in),
        .dev_mode_in(dev_mode_in), .minipci_in(minipci_in), .clkrun_n_in(clkrun_n_in),
        .inta_n_out(inta_n_out), .intb_n_out(intb_n_out), .intb_oe_out(intb_oe_out),
        .pme_n_out(pme_n_out), .uart_clk_en_out(uart_clk_en_out),
        .bar_en_f0_out(bar_en_f0_out), .bar_en_f1_out(bar_en_f1_out));
    pcirq_host i_pcirq_host (.clk_sys_in(clk_sys_in), .inta_n_in(inta_n_out),
        .intb_n_in(intb_n_out), .intb_oe_in(intb_oe_out), .pme_n_in(pme_n_out),
        .irq_a_out(irq_a), .irq_b_out(irq_b), .pme_out(pme));
    ////////////////////////////////////////////////////////////////////////////////
    always #5 clk_sys_in = ~clk_sys_in;
    always @(posedge clk_sys_in) begin
        cycles = cycles + 1;
        if (cycles == 5000) begin
            num_errors = num_errors + 1;
            summarize;
        end
    end
    task summarize;
        begin
            $display("checks %0d mismatches %0d", checked, num_errors);
            if (num_errors == 0 && checked > 0) begin
                $display("*** PASS ***");
            end else begin
                $display("*** FAIL ***");
            end
            $finish;
        end
    endtask
    task chk(input string what, input [31:0] seen, input [31:0] exp);
        begin
            checked = checked + 1;
            if (seen !== exp) begin
                num_errors = num_errors + 1;
                $display("unexpected %s: expected %h seen %h", what, exp, seen);
            end
        end
    endtask
    task cyc(input integer n);
        begin
            repeat (n) @(posedge clk_sys_in);
            #1;
        end
    endtask
    // One access, then an idle cycle so strobes never toggle twice in a step
    task acc(input w, input cf, input [7:0] a, input [31:0] d);
        begin
            reg_wr_in = w;
            reg_rd_in = !w;
            reg_cfg_in = cf;
            reg_addr_in = a;
            reg_wdata_in = d;
            cyc(1);
            rd = reg_rdata_out;
            chk("ack", reg_ack_out, 1);
            reg_wr_in = 1'h0;
            reg_rd_in = 1'h0;
            cyc(1);
        end
    endtask
    task eel(input [7:0] p, input [1:0] m);
        begin
            ee_pin_f0_in = p;
            ee_umask_in = m;
            ee_load_in = 1'h1;
            cyc(1);
            ee_load_in = 1'h0;
            cyc(3);
        end
    endtask
    function [7:0] flen(input integer m);
        flen = (m == 1) ? 8'h14 : (m == 2) ? 8'h28 : 8'h32;
    endfunction
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        void'($urandom(32'h6836_3097));
        cyc(16);
        resetn_in = 1'h1;
        cyc(4);
        for (i = 0; i < 2; i = i + 1) begin
            reg_func_in = i[0];
            acc(0, 0, 8'h1C, 0);
            chk("global", rd, 32'hfff3_0000);
        end
        reg_func_in = 1'h0;
        acc(0, 0, 8'h08, 0);
        chk("unmapped", rd, 0);
        for (i = 0; i < 6; i = i + 1) begin
            rnd = $urandom;
            multi_purpose_pin_in = rnd[10:0];
            pol = rnd[21:11];
            acc(1, 0, 8'h04, {21'h0, pol});
            cyc(4);
            acc(0, 0, 8'h1C, 0);
            chk("pins", rd[14:4], multi_purpose_pin_in ^ pol);
        end
        acc(1, 0, 8'h04, 0);
        multi_purpose_pin_in = 11'h020;
        cyc(5);
        chk("pin irq", irq_a, 1);
        acc(1, 0, 8'h1C, 32'h8033_0000);
        cyc(3);
        chk("pin masked", irq_a, 0);
        multi_purpose_pin_in = 11'h000;
        $display("test pins done");
        acc(1, 0, 8'h1C, 32'hfff3_0000);
        uart_irq_in = 2'h1;
        uart_source_summary_in = 24'h00_0040;
        cyc(3);
        acc(0, 0, 8'h1C, 0);
        chk("uart status", rd[1:0], 2'h1);
        chk("uart irq", irq_a, 1);
        acc(1, 0, 8'h1C, 32'hfff0_0000);
        cyc(3);
        chk("uart masked", irq_a, 0);
        for (i = 0; i < 4; i = i + 1) begin
            eel(i[7:0], 2'h3);
            chk("route", {irq_b, irq_a}, {i == 2, i == 1});
        end
        ee_pin_f1_in = 8'h02;
        multi_purpose_pin_in = 11'h008;
        eel(8'h00, 2'h3);
        cyc(2);
        chk("route f1", {irq_b, irq_a}, 2'h2);
        ee_pin_f1_in = 8'h01;
        multi_purpose_pin_in = 11'h000;
        eel(8'h01, 2'h0);
        acc(0, 0, 8'h1C, 0);
        chk("ee mask", {rd[17:16], irq_a}, 0);
        eel(8'h01, 2'h3);
        $display("test uart routing done");
        acc(1, 1, 8'h44, 32'h0000_0003);
        uart_wake_in = 2'h1;
        cyc(3);
        chk("pme off", pme, 0);
        chk("d3 gating", {uart_clk_en_out, bar_en_f1_out, irq_a}, 3'h2);
        acc(0, 0, 8'h1C, 0);
        chk("bar read", rd, 0);
        acc(1, 1, 8'h44, 32'h0000_0103);
        cyc(3);
        chk("pme on", pme, 1);
        uart_wake_in = 2'h0;
        acc(0, 1, 8'h44, 0);
        chk("pm csr", {rd[15:0], pme}, 17'h1_0207);
        acc(1, 1, 8'h44, 32'h0000_8103);
        cyc(3);
        chk("pme clear", pme, 0);
        acc(1, 1, 8'h44, 0);
        cyc(3);
        chk("d0 clock", uart_clk_en_out, 1);
        uart_irq_in = 2'h0;
        uart_source_summary_in = 24'h00_0041;
        $display("test power states done");
        for (i = 1; i < 4; i = i + 1) begin
            acc(1, 0, 8'h00, {25'h0, i[1:0], 5'h0});
            uart_idle_in = 2'h3;
            cyc(8);
            uart_idle_in = 2'h1;
            cyc(2);
            uart_idle_in = 2'h3;
            cyc(flen(i) - 5);
            acc(0, 0, 8'h1C, 0);
            chk("pd early", rd[5], 0);
            cyc(10);
            chk("pd irq", irq_a, 1);
            acc(0, 0, 8'h1C, 0);
            chk("pd status", rd[5], 1);
            uart_idle_in = 2'h0;
            cyc(2);
            acc(0, 0, 8'h1C, 0);
            chk("pd held", rd[5], 1);
            acc(0, 0, 8'h1C, 0);
            chk("pd cleared", rd[5], 0);
        end
        acc(1, 0, 8'h00, 0);
        $display("test power-down done");
        dev_mode_in = 1'h1;
        multi_purpose_pin_in = 11'h001;
        for (i = 0; i < 2; i = i + 1) begin
            par_irq_in = i[0];
            cyc(4);
            acc(0, 0, 8'h1C, 0);
            chk("shared bit", rd[4], i[0]);
        end
        minipci_in = 1'h1;
        for (i = 0; i < 2; i = i + 1) begin
            clkrun_n_in = i[0];
            cyc(5);
            chk("clkrun", {intb_oe_out, intb_n_out}, {1'h0, i[0]});
        end
        $display("test modes done");
        summarize;
    end
endmodule // pcirq_top_tb
